// ===== common/fld_pkg.sv
/*
 package of the frequency level detector: register indices, reset values,
 output function codes, scaling constants and the detector status carrier.
 assumes frequencies in units of 0.01 Hz and percentages in units of 0.1 %.
*/
`default_nettype none

package fld_pkg;

   // ------------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ------------------------------------------------------------------
   localparam int unsigned IDX_W                  = 14;
   localparam logic [13:0] IDX_DIGITAL_OUT_SELECT = 14'h0a01; // terminal function
   localparam logic [13:0] IDX_CONTACT_OUTPUT_SELECT       = 14'h0a02; // contact function
   localparam logic [13:0] IDX_THRESHOLD_ONE      = 14'h0a14; // level one threshold
   localparam logic [13:0] IDX_HYSTERESIS_ONE     = 14'h0a15; // level one hysteresis
   localparam logic [13:0] IDX_THRESHOLD_TWO      = 14'h0a16; // level two threshold
   localparam logic [13:0] IDX_HYSTERESIS_TWO     = 14'h0a17; // level two hysteresis
   localparam logic [13:0] IDX_ARRIVAL_PERCENT    = 14'h0a18; // arrival band width
   localparam logic [13:0] IDX_MAXIMUM_FREQUENCY  = 14'h0a40; // maximum frequency
   localparam logic [13:0] IDX_DETECTOR_STATUS    = 14'h0a41; // read-only status

   // ------------------------------------------------------------------
   // reset values and limits
   // ------------------------------------------------------------------
   localparam logic [15:0] RESET_DIGITAL_OUT_SELECT = 16'h0002;
   localparam logic [15:0] RESET_CONTACT_OUTPUT_SELECT       = 16'h0008;
   localparam logic [15:0] RESET_THRESHOLD          = 16'h01f4; // 5.00 Hz
   localparam logic [15:0] RESET_PERCENT            = 16'h0000; // 0.0 %
   localparam logic [15:0] RESET_MAXIMUM_FREQUENCY  = 16'h1388; // 50.00 Hz, plain default
   localparam logic [15:0] PERCENT_FULL_SCALE       = 16'h03e8; // 100.0 %
   localparam logic [15:0] SELECT_CODE_MAX          = 16'h0023; // codes 0 to 35
   localparam logic [31:0] PERCENT_DIVISOR          = 32'h0000_03e8;

   // ------------------------------------------------------------------
   // output function codes
   // ------------------------------------------------------------------
   localparam logic [15:0] CODE_LEVEL_ONE = 16'h000f; // 15
   localparam logic [15:0] CODE_LEVEL_TWO = 16'h0010; // 16
   localparam logic [15:0] CODE_ARRIVAL   = 16'h0011; // 17

   // ------------------------------------------------------------------
   // timing of the control sample tick
   // ------------------------------------------------------------------
   localparam int unsigned CLOCK_PERIOD_NS  = 100;
   localparam int unsigned SAMPLE_PERIOD_NS = 1000;
   localparam int unsigned SAMPLE_CYCLES    =
      (SAMPLE_PERIOD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

   // detector statuses travel together
   typedef struct packed {
      logic arrival;   // operating frequency within arrival band
      logic level_two; // second level detector
      logic level_one; // first level detector
   } fld_status_t;

endpackage

`default_nettype wire

// ===== hdl/fld_top.sv
/*
 frequency level detector: two hysteretic level detectors, one arrival
 detector, an apb register slave and two routed status outputs.
 assumes the operating and set frequencies come from logic on the same
 clock, in units of 0.01 Hz, and an apb master with 16-bit byte addresses.
*/
// The APB slave port was chosen for this implementation.
//
// Summary of operation
// - code 15 routes level one status out
// - code 16 routes level two status out
// - code 17 routes arrival status out
// - level one sets above its threshold
// - level one clears below threshold minus hysteresis percent of threshold
// - hysteresis acts only on falling frequency
// - level two sets above its threshold
// - level two clears below its own band
// - thresholds default 5.00 Hz, limited to maximum
// - arrival true within set frequency plus/minus band
// - band is percent times maximum, 0..100 %
`timescale 1ns/1ns
`default_nettype none

module fld_top #(
   parameter int unsigned SAMPLE_CYCLES = fld_pkg::SAMPLE_CYCLES // cycles per tick
) (
   input  wire logic        clock,              // 10 MHz system clock
   input  wire logic        rstn,               // synchronous reset, active low
   input  wire logic        psel,               // apb select
   input  wire logic        penable,            // apb access phase
   input  wire logic        pwrite,             // apb direction
   input  wire logic [15:0] paddr,              // apb byte address
   input  wire logic [31:0] pwdata,             // apb write data
   output var  logic [31:0] prdata,             // apb read data
   output var  logic        pready,             // apb ready
   output var  logic        pslverr,            // apb error
   input  wire logic [15:0] operating_frequency, // present output frequency
   input  wire logic [15:0] set_frequency,       // commanded frequency
   output var  logic        digital_output,     // routed terminal status
   output var  logic        contact_output      // routed contact_output status
);

   // ------------------------------------------------------------------
   // register storage
   // ------------------------------------------------------------------
   logic [15:0] digital_output_function_select;      // terminal function code
   logic [15:0] contact_output_function_select;               // contact_output function code
   logic [15:0] level_threshold [2];                 // threshold per detector
   logic [15:0] level_hysteresis [2];                // hysteresis per detector
   logic [15:0] arrival_band_percent;                // arrival width percent
   logic [15:0] maximum_frequency_setting;           // maximum frequency
   logic [15:0] next_digital_output_function_select; // next terminal code
   logic [15:0] next_contact_output_function_select;          // next contact_output code
   logic [15:0] next_level_threshold [2];            // next thresholds
   logic [15:0] next_level_hysteresis [2];           // next hystereses
   logic [15:0] next_arrival_band_percent;           // next arrival percent
   logic [15:0] next_maximum_frequency_setting;      // next maximum
   logic [31:0] next_prdata;                         // next read data
   logic        next_pready;                         // next ready
   logic        next_pslverr;                        // next error

   // ------------------------------------------------------------------
   // detector state
   // ------------------------------------------------------------------
   fld_pkg::fld_status_t status;      // registered detector statuses
   fld_pkg::fld_status_t next_status; // statuses after this cycle
   wire logic [1:0]      next_level;  // level detector next values
   logic [15:0]          tick_count;  // sample divider count
   logic [15:0]          next_tick_count;
   logic                 tick;        // one-cycle sample enable
   logic                 next_tick;
   logic                 next_digital_output;
   logic                 next_contact_output;

   // ------------------------------------------------------------------
   // apb slave
   // ------------------------------------------------------------------
   logic        access;     // access phase in progress
   logic        commit;     // edge at which the transfer completes
   logic [13:0] reg_index;  // word index from byte address
   logic        aligned;    // low address bits clear
   logic [15:0] wvalue;     // low half of write data

   // one wait state: pready rises in the second access cycle, so the read
   // data and the error answer can be registered before they are shown
   always_comb begin
      access    = psel & penable;
      commit    = access & pready;
      reg_index = paddr[15:2];
      aligned   = (paddr[1:0] == 2'b00);
      wvalue    = pwdata[15:0];
   end

   // register next values, read mux and write acceptance
   always_comb begin
      next_digital_output_function_select = digital_output_function_select;
      next_contact_output_function_select          = contact_output_function_select;
      next_level_threshold                = level_threshold;
      next_level_hysteresis               = level_hysteresis;
      next_arrival_band_percent           = arrival_band_percent;
      next_maximum_frequency_setting      = maximum_frequency_setting;
      next_pready                         = access & ~pready;
      next_prdata                         = 32'h0000_0000;
      next_pslverr                        = 1'b0;
      if (access & ~pready) begin
         // first access cycle: decide the answer
         unique case ({aligned, reg_index})
            {1'b1, fld_pkg::IDX_DIGITAL_OUT_SELECT}: begin
               next_prdata  = {16'h0000, digital_output_function_select};
               next_pslverr = pwrite & (wvalue > fld_pkg::SELECT_CODE_MAX);
            end
            {1'b1, fld_pkg::IDX_CONTACT_OUTPUT_SELECT}: begin
               next_prdata  = {16'h0000, contact_output_function_select};
               next_pslverr = pwrite & (wvalue > fld_pkg::SELECT_CODE_MAX);
            end
            {1'b1, fld_pkg::IDX_THRESHOLD_ONE}: begin
               next_prdata  = {16'h0000, level_threshold[0]};
               // a threshold above the maximum frequency is refused
               next_pslverr = pwrite & (wvalue > maximum_frequency_setting);
            end
            {1'b1, fld_pkg::IDX_HYSTERESIS_ONE}: begin
               next_prdata  = {16'h0000, level_hysteresis[0]};
               next_pslverr = pwrite & (wvalue > fld_pkg::PERCENT_FULL_SCALE);
            end
            {1'b1, fld_pkg::IDX_THRESHOLD_TWO}: begin
               next_prdata  = {16'h0000, level_threshold[1]};
               next_pslverr = pwrite & (wvalue > maximum_frequency_setting);
            end
            {1'b1, fld_pkg::IDX_HYSTERESIS_TWO}: begin
               next_prdata  = {16'h0000, level_hysteresis[1]};
               next_pslverr = pwrite & (wvalue > fld_pkg::PERCENT_FULL_SCALE);
            end
            {1'b1, fld_pkg::IDX_ARRIVAL_PERCENT}: begin
               next_prdata  = {16'h0000, arrival_band_percent};
               next_pslverr = pwrite & (wvalue > fld_pkg::PERCENT_FULL_SCALE);
            end
            {1'b1, fld_pkg::IDX_MAXIMUM_FREQUENCY}: begin
               next_prdata  = {16'h0000, maximum_frequency_setting};
            end
            {1'b1, fld_pkg::IDX_DETECTOR_STATUS}: begin
               // status is read-only; a write is answered with an error
               next_prdata  = {29'h0000_0000, status};
               next_pslverr = pwrite;
            end
            default: begin
               // unmapped or misaligned: zero data and an error
               next_pslverr = 1'b1;
            end
         endcase
      end
      if (commit & pwrite & ~pslverr) begin
         // writes land only at the completing edge
         unique case (reg_index)
            fld_pkg::IDX_DIGITAL_OUT_SELECT: next_digital_output_function_select = wvalue;
            fld_pkg::IDX_CONTACT_OUTPUT_SELECT:       next_contact_output_function_select          = wvalue;
            fld_pkg::IDX_THRESHOLD_ONE:      next_level_threshold[0]             = wvalue;
            fld_pkg::IDX_HYSTERESIS_ONE:     next_level_hysteresis[0]            = wvalue;
            fld_pkg::IDX_THRESHOLD_TWO:      next_level_threshold[1]             = wvalue;
            fld_pkg::IDX_HYSTERESIS_TWO:     next_level_hysteresis[1]            = wvalue;
            fld_pkg::IDX_ARRIVAL_PERCENT:    next_arrival_band_percent           = wvalue;
            fld_pkg::IDX_MAXIMUM_FREQUENCY:  next_maximum_frequency_setting      = wvalue;
            default: ;                       // status has no storage
         endcase
      end
      if (commit) begin
         next_prdata  = 32'h0000_0000;
         next_pslverr = 1'b0;
      end
   end

   // register file and bus answer flip-flops
   always_ff @(posedge clock) begin
      if (!rstn) begin
         digital_output_function_select <= fld_pkg::RESET_DIGITAL_OUT_SELECT;
         contact_output_function_select          <= fld_pkg::RESET_CONTACT_OUTPUT_SELECT;
         level_threshold[0]             <= fld_pkg::RESET_THRESHOLD;
         level_threshold[1]             <= fld_pkg::RESET_THRESHOLD;
         level_hysteresis[0]            <= fld_pkg::RESET_PERCENT;
         level_hysteresis[1]            <= fld_pkg::RESET_PERCENT;
         arrival_band_percent           <= fld_pkg::RESET_PERCENT;
         maximum_frequency_setting      <= fld_pkg::RESET_MAXIMUM_FREQUENCY;
         prdata                         <= 32'h0000_0000;
         pready                         <= 1'b0;
         pslverr                        <= 1'b0;
      end else begin
         digital_output_function_select <= next_digital_output_function_select;
         contact_output_function_select          <= next_contact_output_function_select;
         level_threshold                <= next_level_threshold;
         level_hysteresis               <= next_level_hysteresis;
         arrival_band_percent           <= next_arrival_band_percent;
         maximum_frequency_setting      <= next_maximum_frequency_setting;
         prdata                         <= next_prdata;
         pready                         <= next_pready;
         pslverr                        <= next_pslverr;
      end
   end

   // ------------------------------------------------------------------
   // sample tick divider
   // ------------------------------------------------------------------

   // counts clock cycles and pulses tick once per sample period
   always_comb begin
      if (tick_count >= 16'(SAMPLE_CYCLES - 1)) begin
         next_tick_count = 16'h0000;
         next_tick       = 1'b1;
      end else begin
         next_tick_count = tick_count + 16'h0001;
         next_tick       = 1'b0;
      end
   end

   // divider flip-flops
   always_ff @(posedge clock) begin
      if (!rstn) begin
         tick_count <= 16'h0000;
         tick       <= 1'b0;
      end else begin
         tick_count <= next_tick_count;
         tick       <= next_tick;
      end
   end

   // ------------------------------------------------------------------
   // level detectors, one per threshold
   // ------------------------------------------------------------------
   // each detector sees only its own threshold and hysteresis, so the two
   // never influence one another
   for (genvar i = 0; i < 2; i++) begin : g_level
      wire logic [31:0] lag_product;  // threshold times hysteresis percent
      wire logic [15:0] lag;          // lag in frequency units
      wire logic [15:0] release_point; // falling release frequency
      assign lag_product   = 32'(level_threshold[i]) * 32'(level_hysteresis[i]);
      assign lag           = 16'(lag_product / fld_pkg::PERCENT_DIVISOR);
      // percent is limited to full scale, so lag never exceeds the threshold
      assign release_point = level_threshold[i] - lag;
      // rising: bare threshold; falling: hold until below release point
      assign next_level[i] =
         (operating_frequency > level_threshold[i]) ? 1'b1 :
         (operating_frequency < release_point)      ? 1'b0 :
         (i == 0) ? status.level_one : status.level_two;
   end

   // ------------------------------------------------------------------
   // arrival detector and status update
   // ------------------------------------------------------------------
   logic [31:0] band_product; // maximum frequency times arrival percent
   logic [15:0] band;         // arrival half width
   logic [16:0] band_low;     // lower edge, floored at zero
   logic [16:0] band_high;    // upper edge, one bit wider to avoid wrap

   // statuses only move on a sample tick
   always_comb begin
      band_product = 32'(maximum_frequency_setting) * 32'(arrival_band_percent);
      band         = 16'(band_product / fld_pkg::PERCENT_DIVISOR);
      band_low     = (set_frequency > band) ? 17'(set_frequency - band) : 17'h0_0000;
      band_high    = 17'(set_frequency) + 17'(band);
      next_status  = status;
      if (tick) begin
         next_status.level_one = next_level[0];
         next_status.level_two = next_level[1];
         next_status.arrival   = (17'(operating_frequency) >= band_low) &&
                                 (17'(operating_frequency) <= band_high);
      end
   end

   // status flip-flops
   always_ff @(posedge clock) begin
      if (!rstn) begin
         status <= '0;
      end else begin
         status <= next_status;
      end
   end

   // ------------------------------------------------------------------
   // output routing
   // ------------------------------------------------------------------

   // codes outside this block's functions drive the output inactive
   function automatic logic route_status(input logic [15:0]          code,
                                         input fld_pkg::fld_status_t s);
      logic result;
      result = 1'b0;
      if (code == fld_pkg::CODE_LEVEL_ONE) begin
         result = s.level_one;
      end else if (code == fld_pkg::CODE_LEVEL_TWO) begin
         result = s.level_two;
      end else if (code == fld_pkg::CODE_ARRIVAL) begin
         result = s.arrival;
      end
      return result;
   endfunction

   // selects the routed status for each terminal
   always_comb begin
      next_digital_output = route_status(digital_output_function_select, status);
      next_contact_output = route_status(contact_output_function_select, status);
   end

   // output flip-flops, one cycle behind the status registers
   always_ff @(posedge clock) begin
      if (!rstn) begin
         digital_output <= 1'b0;
         contact_output <= 1'b0;
      end else begin
         digital_output <= next_digital_output;
         contact_output <= next_contact_output;
      end
   end

endmodule // fld_top

`default_nettype wire

// ===== dv/fld_terminal_model.sv
/*
 terminal equipment model: samples the digital output terminal and the contact_output contact.
 assumes both pins are levels on the design clock; the equipment reads them one clock late.
*/
`timescale 1ns/1ns
`default_nettype none
module fld_terminal_model (
   input  wire logic clock,          // design clock
   input  wire logic digital_output, // terminal pin
   input  wire logic contact_output, // contact_output pin
   output var  logic do_seen,        // terminal level as seen by the equipment
   output var  logic rl_seen         // contact_output level as seen by the equipment
);
   // ------------------------------------------------------------------
   // input stage: one register, so a glitch-free level is all it needs
   // ------------------------------------------------------------------
   always_ff @(posedge clock) begin
      do_seen <= digital_output;
      rl_seen <= contact_output;
   end
endmodule // fld_terminal_model
`default_nettype wire

// ===== dv/fld_top_sva.sv
/*
 checker of the fld_top ports: apb answer timing, refusals, quiet start after reset.
 assumes one clock domain and a master that keeps the apb handshake.
*/
`timescale 1ns/1ns
`default_nettype none
module fld_top_sva #(
   parameter int unsigned SAMPLE_CYCLES = 10 // cycles per tick
) (
   input wire logic        clock,
   input wire logic        rstn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [15:0] operating_frequency,
   input wire logic [15:0] set_frequency,
   input wire logic        digital_output,
   input wire logic        contact_output
);
   // ------------------------------------------------------------------
   // helper: cycles since reset release, saturating so it never wraps
   // ------------------------------------------------------------------
   int unsigned since_rst; // cycle count after release
   always_ff @(posedge clock) begin
      if (!rstn) since_rst <= 0;
      else if (since_rst < 1000) since_rst <= since_rst + 1;
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   sequence s_setup; psel && !penable; endsequence
   sequence s_wait; psel && penable && !pready; endsequence
   AST_ONE_WAIT: assert property (s_setup |=> s_wait ##1 pready)
      else $error("ready not in second access cycle");
   AST_READY_PULSE: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   AST_READY_QUAL: assert property (pready |-> psel && penable && $past(psel))
      else $error("ready outside an access");
   AST_IDLE_DATA: assert property (!pready |-> prdata == 32'h0000_0000)
      else $error("read data outside answer");
   AST_UPPER_ZERO: assert property (pready |-> prdata[31:16] == 16'h0000)
      else $error("upper read data not zero");
   AST_ERR_QUAL: assert property (pslverr |-> pready)
      else $error("error without ready");
   AST_MISALIGN: assert property (pready && paddr[1:0] != 2'b00 |-> pslverr)
      else $error("misaligned access accepted");
   AST_UNMAPPED: assert property (pready && !pwrite && paddr[15:12] != 4'h2
      |-> pslverr && prdata == 32'h0000_0000)
      else $error("unmapped read accepted");
   AST_STATUS_RO: assert property (pready && pwrite && paddr == 16'h2904 |-> pslverr)
      else $error("status write accepted");
   AST_QUIET_START: assert property (since_rst <= SAMPLE_CYCLES
      |-> !digital_output && !contact_output)
      else $error("output before first tick");
endmodule // fld_top_sva
bind fld_top fld_top_sva #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_sva (.clock(clock), .rstn(rstn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .operating_frequency(operating_frequency),
   .set_frequency(set_frequency), .digital_output(digital_output), .contact_output(contact_output));
`default_nettype wire

// ===== dv/fld_top_test.sv
/*
 self-checking bench of fld_top: apb register access, level and arrival detectors, routing.
 assumes the terminal model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ns
`default_nettype none
module fld_top_test;
   localparam int unsigned SC = 4; // shortened tick keeps the run brief
   logic clock = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [15:0] paddr = 16'h0000, opf = 16'h0000, setf = 16'h0000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rng = 32'h0000_0062;
   logic pready, pslverr, dout, cout, do_seen, rl_seen, l1 = 1'b0, l2 = 1'b0, ar = 1'b0;
   logic [33:0] expq[$], e_cur; // {check data, error, data}
   int n_fail = 0, checked = 0, thr1 = 500, h1 = 0, thr2 = 500, h2 = 0, pct = 0;
   int sel_do = 2, sel_rl = 8;
   always #50 clock = ~clock;
   fld_top #(.SAMPLE_CYCLES(SC)) u_dut (.clock(clock), .rstn(rstn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .operating_frequency(opf), .set_frequency(setf),
      .digital_output(dout), .contact_output(cout));
   fld_terminal_model u_ext (.clock(clock), .digital_output(dout), .contact_output(cout),
      .do_seen(do_seen), .rl_seen(rl_seen));
   // ------------------------------------------------------------------
   // helpers: random source, report, apb master
   // ------------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   function automatic logic route(input int c);
      return (c == 15) ? l1 : (c == 16) ? l2 : (c == 17) ? ar : 1'b0; // unused codes give 0
   endfunction
   task automatic final_report;
      if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic bad(input logic [31:0] g, input logic [31:0] e);
      n_fail++;
      $display("Error at %0t got %h expected %h", $time, g, e);
   endtask
   // one transfer; an idle cycle before setup avoids a double drive of psel
   task automatic apb(input logic wr, input logic [15:0] a, input logic [15:0] d,
                      input logic [15:0] ed, input logic ee, input logic cd);
      @(posedge clock);
      expq.push_back({cd, ee, 16'h0000, ed});
      psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= {16'h0000, d};
      @(posedge clock) penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task automatic wr(input logic [13:0] i, input int d, input logic ee);
      apb(1'b1, {i, 2'b00}, d[15:0], 16'h0000, ee, 1'b0);
   endtask
   task automatic rd(input logic [13:0] i, input int d, input logic ee);
      apb(1'b0, {i, 2'b00}, 16'h0000, d[15:0], ee, 1'b1);
   endtask
   // one operating point: update the bench model, let two ticks pass, check pins and status
   task automatic step(input int op, input int sf);
      int band, lo;
      opf <= op[15:0]; setf <= sf[15:0];
      if (op > thr1) l1 = 1'b1; else if (op < thr1 - thr1 * h1 / 1000) l1 = 1'b0;
      if (op > thr2) l2 = 1'b1; else if (op < thr2 - thr2 * h2 / 1000) l2 = 1'b0;
      band = 5000 * pct / 1000;
      lo = (sf > band) ? sf - band : 0;
      ar = (op >= lo) && (op <= sf + band);
      repeat (2 * SC + 3) @(posedge clock);
      checked += 2;
      if (do_seen !== route(sel_do)) bad(do_seen, route(sel_do));
      if (rl_seen !== route(sel_rl)) bad(rl_seen, route(sel_rl));
      rd(fld_pkg::IDX_DETECTOR_STATUS, {ar, l2, l1}, 1'b0);
   endtask
   // ------------------------------------------------------------------
   // monitor: each answer is matched against the oldest note
   // ------------------------------------------------------------------
   always @(posedge clock) begin
      if (pready === 1'b1) begin
         if (expq.size() == 0) bad(prdata, 32'h0);
         else begin
            e_cur = expq.pop_front();
            checked++;
            if (pslverr !== e_cur[32]) bad({31'h0, pslverr}, {31'h0, e_cur[32]});
            if (e_cur[33] && prdata !== e_cur[31:0]) bad(prdata, e_cur[31:0]);
         end
      end
   end
   initial begin
      #(100 * 30000);
      n_fail++;
      final_report();
   end
   // ------------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------------
   initial begin
      repeat (12) @(posedge clock);
      rstn <= 1'b1;
      rd(fld_pkg::IDX_DIGITAL_OUT_SELECT, 2, 1'b0);
      rd(fld_pkg::IDX_CONTACT_OUTPUT_SELECT, 8, 1'b0);
      rd(fld_pkg::IDX_THRESHOLD_ONE, 500, 1'b0);
      rd(fld_pkg::IDX_THRESHOLD_TWO, 500, 1'b0);
      rd(fld_pkg::IDX_HYSTERESIS_ONE, 0, 1'b0);
      rd(fld_pkg::IDX_ARRIVAL_PERCENT, 0, 1'b0);
      rd(fld_pkg::IDX_DETECTOR_STATUS, 4, 1'b0);
      rd(14'h0100, 0, 1'b1);
      apb(1'b0, 16'h2852, 16'h0000, 16'h0000, 1'b1, 1'b0);
      wr(fld_pkg::IDX_THRESHOLD_ONE, 5001, 1'b1);
      rd(fld_pkg::IDX_THRESHOLD_ONE, 500, 1'b0);
      wr(fld_pkg::IDX_THRESHOLD_TWO, 5000, 1'b0);
      rd(fld_pkg::IDX_THRESHOLD_TWO, 5000, 1'b0);
      wr(fld_pkg::IDX_ARRIVAL_PERCENT, 1001, 1'b1);
      wr(fld_pkg::IDX_ARRIVAL_PERCENT, 1000, 1'b0);
      rd(fld_pkg::IDX_ARRIVAL_PERCENT, 1000, 1'b0);
      wr(fld_pkg::IDX_DIGITAL_OUT_SELECT, 36, 1'b1);
      wr(fld_pkg::IDX_DETECTOR_STATUS, 7, 1'b1);
      thr2 = 5000; pct = 1000; // model follows the accepted writes
      step(200, 3000);
      thr1 = 1000; h1 = 100; thr2 = 2000; h2 = 0; pct = 100; sel_do = 15; sel_rl = 16;
      wr(fld_pkg::IDX_THRESHOLD_ONE, thr1, 1'b0);
      wr(fld_pkg::IDX_HYSTERESIS_ONE, h1, 1'b0);
      wr(fld_pkg::IDX_THRESHOLD_TWO, thr2, 1'b0);
      wr(fld_pkg::IDX_HYSTERESIS_TWO, h2, 1'b0);
      wr(fld_pkg::IDX_ARRIVAL_PERCENT, pct, 1'b0);
      wr(fld_pkg::IDX_DIGITAL_OUT_SELECT, sel_do, 1'b0);
      wr(fld_pkg::IDX_CONTACT_OUTPUT_SELECT, sel_rl, 1'b0);
      step(1001, 3000); step(950, 3000); step(1000, 3000); step(899, 3000);
      step(1000, 3000); step(2001, 3000); step(1999, 3000);
      sel_do = 17; sel_rl = 15;
      wr(fld_pkg::IDX_DIGITAL_OUT_SELECT, sel_do, 1'b0);
      wr(fld_pkg::IDX_CONTACT_OUTPUT_SELECT, sel_rl, 1'b0);
      step(2500, 3000); step(2499, 3000); step(3500, 3000); step(3501, 3000);
      step(100, 50);
      for (int k = 0; k < 10; k++) begin
         rng = xs(rng);
         step(int'(rng[11:0]), int'(rng[27:16]));
      end
      final_report();
   end
endmodule // fld_top_test
`default_nettype wire
